// ---- scpt_cfg.svh ----
/*
  Register offsets, field positions, reset values and timing counts for the
  system clock prescaler and oscillator trim block.
  Assumes a 10 MHz master clock and a plain strobe-based register port.
*/
`ifndef SCPT_CFG_SVH
`define SCPT_CFG_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define SCPT_ADDR_W          4
`define SCPT_OFF_TRIM        4'h0
`define SCPT_OFF_PRESCALE    4'h1
`define SCPT_OFF_STATUS      4'h2

// ****************************************************************
// Field positions and codes
// ****************************************************************
`define SCPT_PCE_BIT         7
`define SCPT_DIV_LSB         0
`define SCPT_DIV_MSB         3
`define SCPT_DIV_RST_PLAIN   4'h0
`define SCPT_DIV_RST_EIGHT   4'h3
`define SCPT_DIV_MAX         4'h8
`define SCPT_SRC_EXTERNAL    4'h0
`define SCPT_SRC_RC          4'h2
`define SCPT_STARTUP_NONE    2'h0
`define SCPT_STARTUP_SHORT   2'h1
`define SCPT_STARTUP_LONG    2'h2

// ****************************************************************
// Timing
// ****************************************************************
`define SCPT_CLK_KHZ         10000
`define SCPT_PCE_WINDOW      4
`define SCPT_WAKE_CK         6
`define SCPT_RESET_CK        14
`define SCPT_SHORT_US        4100
`define SCPT_LONG_US         65000
// Longest waits round down: kHz * us / 1000
`define SCPT_SHORT_CYC       ((`SCPT_CLK_KHZ * `SCPT_SHORT_US) / 1000)
`define SCPT_LONG_CYC        ((`SCPT_CLK_KHZ * `SCPT_LONG_US) / 1000)

`endif

// ---- scpt_pkg.sv ----
/*
  Types shared by the clock prescale and trim block.
  Assumes the constants header is included by the design file.
*/
package scpt_pkg;

  // Start-up sequencer states
  typedef enum logic [1:0] {
    SCPT_ST_DELAY,
    SCPT_ST_RUN,
    SCPT_ST_WAKE
  } scpt_state_t;

endpackage : scpt_pkg

// ---- scpt_top.sv ----
/*
  System clock prescaler, start-up delay, clock output and oscillator trim.
  Assumes fuses are static straps, the register master runs on sys_clk,
  and the master clock is the undivided selected source.
*/
// Local design decisions: the strobed register port and the placing of the registers.
// Function
// - External clock is used when source fuses hold code 0000.
// - Wake from power-down or power-save takes six clock cycles.
// - Reset delay is 14 cycles, plus 4.1 ms or 65 ms per fuses.
// - Clock-output fuse drives system clock on its pin, even in reset; here only the enable holds, and the pin stays low in reset.
// - Clock output pin carries the divided clock. Here at division 0000 it toggles every cycle, giving half the master clock.
// - Timer oscillator allowed only with RC source; clock four times faster.
// - Prescaler divides I/O, ADC, CPU and flash clock domains.
// - Division change is glitch free, no shorter intermediate period.
// - New rate active after T1+T2 to T1+2*T2, two active edges between.
// - Change-enable sets only when all other bits are written zero.
// - Change-enable clears after four cycles or on value write; no restart.
// - Division resets to 0000, or 0011 with divide-by-eight fuse. Here it holds 0000 in reset and loads on the first clock after release.
// - Any value written through the sequence is accepted.
// - Value n selects divide by 2^n up to 256; 9 to 15 reserved.
// - Trim loads factory calibration during reset; software may rewrite. Here it loads on the first clock after release.
// - Top trim bit selects range; ranges overlap.
// - Lower seven trim bits tune monotonically within range.
`timescale 1ns/1ns
`include "scpt_cfg.svh"

module scpt_top
  import scpt_pkg::*;
#(
  parameter int unsigned SHORT_CYC = `SCPT_SHORT_CYC,
  parameter int unsigned LONG_CYC  = `SCPT_LONG_CYC
) (
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  // Fuses
  input  wire logic [3:0]                clock_source_select_fuses,
  input  wire logic [1:0]                startup_time_fuses,
  input  wire logic                      clock_output_fuse,
  input  wire logic                      divide_by_eight_fuse,
  input  wire logic [7:0]                factory_trim,
  // Power events
  input  wire logic                      wake_req,
  input  wire logic                      timer_osc_req,
  // Register port
  input  wire logic [`SCPT_ADDR_W-1:0]   reg_addr,
  input  wire logic [7:0]                reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [7:0]                reg_rdata,
  // Clock results
  output logic                           sys_clk_en,
  output logic                           core_run,
  output logic                           clock_output_pin,
  output logic                           clock_output_oe,
  output logic                           external_clock_used,
  output logic                           timer_osc_enable,
  output logic      [7:0]                oscillator_trim,
  output logic                           trim_range_bit,
  output logic      [6:0]                trim_fine_value
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [7:0]  trim;
    logic [3:0]  div;
    logic        pce;
    logic [2:0]  pce_cnt;
    logic [7:0]  cnt;
    logic        en;
    logic        clk_out;
    logic [3:0]  pend_div;
    logic        pend;
    logic [1:0]  pend_edges;
    scpt_state_t st;
    logic [23:0] dly;
    logic        loaded;
    logic [7:0]  rdata;
  } scpt_state_reg_t;

  scpt_state_reg_t s_reg;
  scpt_state_reg_t s_next;

  // Divide ratio terminal count for code n: 2^n - 1, reserved codes cap at 256
  function automatic logic [7:0] scpt_term(input logic [3:0] n);
    logic [3:0] k;
    k = (n > `SCPT_DIV_MAX) ? `SCPT_DIV_MAX : n;
    scpt_term = 8'((9'h001 << k) - 9'h001);
  endfunction : scpt_term

  // Reset-delay length in cycles for a start-up fuse code
  function automatic logic [23:0] scpt_reset_delay(input logic [1:0] startup_code);
    case (startup_code)
      `SCPT_STARTUP_SHORT: scpt_reset_delay = 24'(`SCPT_RESET_CK + SHORT_CYC);
      `SCPT_STARTUP_LONG:  scpt_reset_delay = 24'(`SCPT_RESET_CK + LONG_CYC);
      default:         scpt_reset_delay = 24'(`SCPT_RESET_CK);
    endcase
  endfunction : scpt_reset_delay

  logic wr_trim;
  logic wr_pre;
  logic pre_arm;
  logic [7:0] term;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  always_comb begin
    s_next  = s_reg;
    wr_trim = reg_wr && (reg_addr == `SCPT_OFF_TRIM);
    wr_pre  = reg_wr && (reg_addr == `SCPT_OFF_PRESCALE);
    pre_arm = wr_pre && (reg_wdata == 8'h80);
    term    = scpt_term(s_reg.div);

    // Strapped values captured on the first clock after release
    if (!s_reg.loaded) begin
      s_next.loaded = 1'b1;
      s_next.trim   = factory_trim;
      s_next.div    = divide_by_eight_fuse ? `SCPT_DIV_RST_EIGHT
                                           : `SCPT_DIV_RST_PLAIN;
      s_next.dly    = scpt_reset_delay(startup_time_fuses);
    end

    // Divider: one enable pulse per divided period
    s_next.en = 1'b0;
    if (s_reg.cnt >= term) begin
      s_next.cnt = 8'h00;
      s_next.en  = 1'b1;
    end else begin
      s_next.cnt = s_reg.cnt + 8'h01;
    end
    // Output square wave from the divided clock; falls at mid-period and rises at period end, or toggles every cycle when term is 0
    if (term == 8'h00) begin
      s_next.clk_out = ~s_reg.clk_out;
    end else if (s_reg.cnt == (term >> 1) || s_reg.cnt >= term) begin
      s_next.clk_out = (s_reg.cnt >= term);
    end

    // Pending division switch: two old-rate edges, then new value on a
    // period boundary, so no period shorter than either setting appears
    if (s_reg.pend && s_reg.en) begin
      if (s_reg.pend_edges == 2'd1) begin
        s_next.div  = s_reg.pend_div;
        s_next.pend = 1'b0;
        s_next.cnt  = 8'h00;
      end
      s_next.pend_edges = s_reg.pend_edges + 2'd1;
    end

    // Change-enable window, counted in current CPU clock cycles
    if (s_reg.pce && s_reg.en) begin
      if (s_reg.pce_cnt == 3'(`SCPT_PCE_WINDOW - 1)) begin
        s_next.pce = 1'b0;
      end
      s_next.pce_cnt = s_reg.pce_cnt + 3'd1;
    end

    // Register writes
    if (wr_trim) begin
      s_next.trim = reg_wdata;
    end
    if (pre_arm && !s_reg.pce) begin
      s_next.pce     = 1'b1;
      s_next.pce_cnt = 3'd0;
    end else if (wr_pre && s_reg.pce && !reg_wdata[`SCPT_PCE_BIT]) begin
      s_next.pce        = 1'b0;
      s_next.pend       = 1'b1;
      s_next.pend_edges = 2'd0;
      s_next.pend_div   = reg_wdata[`SCPT_DIV_MSB:`SCPT_DIV_LSB];
    end

    // Start-up sequencer
    case (s_reg.st)
      SCPT_ST_DELAY: begin
        if (s_reg.loaded && s_reg.dly <= 24'd1) begin
          s_next.st = SCPT_ST_RUN;
        end else if (s_reg.loaded) begin
          s_next.dly = s_reg.dly - 24'd1;
        end
      end
      SCPT_ST_RUN: begin
        if (wake_req) begin
          s_next.st  = SCPT_ST_WAKE;
          s_next.dly = 24'(`SCPT_WAKE_CK);
        end
      end
      SCPT_ST_WAKE: begin
        if (s_reg.dly <= 24'd1) begin
          s_next.st = SCPT_ST_RUN;
        end else begin
          s_next.dly = s_reg.dly - 24'd1;
        end
      end
      default: s_next.st = SCPT_ST_DELAY;
    endcase

    // Read data appears the cycle after the strobe
    s_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        `SCPT_OFF_TRIM:     s_next.rdata = s_reg.trim;
        `SCPT_OFF_PRESCALE: s_next.rdata = {s_reg.pce, 3'b000, s_reg.div};
        `SCPT_OFF_STATUS:   s_next.rdata = {5'h00, s_reg.pend,
                                            s_reg.st == SCPT_ST_RUN, s_reg.pce};
        default:            s_next.rdata = 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_reg    <= '0;
      s_reg.st <= SCPT_ST_DELAY;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata           = s_reg.rdata;
  assign sys_clk_en          = s_reg.en;
  assign core_run            = (s_reg.st == SCPT_ST_RUN);
  // Pin override holds through reset because the fuse is a static strap
  assign clock_output_oe     = clock_output_fuse;
  assign clock_output_pin    = clock_output_fuse & s_reg.clk_out;
  assign external_clock_used = (clock_source_select_fuses == `SCPT_SRC_EXTERNAL);
  // Timer oscillator shares pins with the crystal, so only the RC source allows it
  assign timer_osc_enable    = timer_osc_req &&
                               (clock_source_select_fuses == `SCPT_SRC_RC);
  assign oscillator_trim     = s_reg.trim;
  assign trim_range_bit      = s_reg.trim[7];
  assign trim_fine_value     = s_reg.trim[6:0];

endmodule : scpt_top

// ---- scpt_top_sva.sv ----
/*
  Port checker for the clock prescale and trim block.
  Assumes it is bound to every scpt_top instance and sees only its ports.
*/
`timescale 1ns/1ns
module scpt_top_chk (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic [3:0] clock_source_select_fuses,
  input wire logic       clock_output_fuse,
  input wire logic       wake_req,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       core_run,
  input wire logic       clock_output_pin,
  input wire logic       clock_output_oe,
  input wire logic       external_clock_used,
  input wire logic       timer_osc_enable,
  input wire logic [7:0] oscillator_trim,
  input wire logic       trim_range_bit,
  input wire logic [6:0] trim_fine_value
);
  // ****************************************
  // Edges since reset, saturating at 15
  // ****************************************
  logic [3:0] up_reg;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) up_reg <= 4'h0;
    else if (up_reg != 4'hf) up_reg <= up_reg + 4'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Margin of two edges below the 15 seen at first run, since the load edge after release is not pinned down
  chk_run_delay: assert property (core_run |-> up_reg >= 4'hd)
    else $error("core ran before start-up delay");
  chk_ext_code: assert property (external_clock_used == (clock_source_select_fuses == 4'h0))
    else $error("external clock select wrong");
  chk_osc_rc: assert property (timer_osc_enable |-> clock_source_select_fuses == 4'h2)
    else $error("timer oscillator without RC source");
  chk_out_en: assert property (clock_output_oe == clock_output_fuse)
    else $error("clock output enable wrong");
  chk_pin_gate: assert property (!clock_output_fuse |-> !clock_output_pin)
    else $error("clock output without fuse");
  chk_trim_wr: assert property (reg_wr && reg_addr == 4'h0 |=> oscillator_trim == $past(reg_wdata))
    else $error("trim write lost");
  chk_trim_hold: assert property ($past(rst_b) && !(reg_wr && reg_addr == 4'h0) |=> $stable(oscillator_trim))
    else $error("trim changed without write");
  chk_trim_split: assert property ({trim_range_bit, trim_fine_value} == oscillator_trim)
    else $error("trim fields wrong");
  chk_trim_read: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata == $past(oscillator_trim))
    else $error("trim read wrong");
  cover property (reg_wr && reg_addr == 4'h1 && reg_wdata == 8'h80);
  cover property (wake_req && core_run);
  cover property (timer_osc_enable);
endmodule : scpt_top_chk

bind scpt_top scpt_top_chk scpt_top_chk_i (.*);

// ---- tb_scpt_top.sv ----
/*
  Testbench for scpt_top: register tasks, protected prescale change, trim.
  Assumes the port checker is bound from its own file.
*/
`timescale 1ns/1ns
module tb_scpt_top;
  logic       sys_clk   = 1'b0;
  logic       rst_b     = 1'b0;
  logic [3:0] src_fuse  = 4'h0;
  logic [3:0] reg_addr  = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr    = 1'b0;
  logic       reg_rd    = 1'b0;
  logic       wake_req  = 1'b0;
  logic       osc_req   = 1'b0;
  logic       out_fuse  = 1'b1;
  logic [7:0] reg_rdata, oscillator_trim;
  logic [6:0] trim_fine_value;
  logic       sys_clk_en, core_run, clock_output_pin, clock_output_oe;
  logic       external_clock_used, timer_osc_enable, trim_range_bit;
  int         n_fail     = 0;
  int         n_compared = 0;

  // Steady master clock, never a jump in rate
  always #50 sys_clk = ~sys_clk;

  // Short delay counts, unused here since start-up fuses 0 select the 14-cycle delay only
  scpt_top #(.SHORT_CYC(20), .LONG_CYC(50)) scpt_top_i (
    .sys_clk(sys_clk), .rst_b(rst_b), .clock_source_select_fuses(src_fuse),
    .startup_time_fuses(2'h0), .clock_output_fuse(out_fuse), .divide_by_eight_fuse(1'b1),
    .factory_trim(8'h5a), .wake_req(wake_req), .timer_osc_req(osc_req),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sys_clk_en(sys_clk_en), .core_run(core_run),
    .clock_output_pin(clock_output_pin), .clock_output_oe(clock_output_oe),
    .external_clock_used(external_clock_used), .timer_osc_enable(timer_osc_enable),
    .oscillator_trim(oscillator_trim), .trim_range_bit(trim_range_bit),
    .trim_fine_value(trim_fine_value));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk(what, exp, reg_rdata);
  endtask : rd

  // Bounded wait for n enable pulses, sampled away from the edge
  task automatic wait_en(input int n);
    int k = 0;
    for (int i = 0; i < 3000 && k < n; i++) begin
      @(negedge sys_clk);
      if (sys_clk_en === 1'b1) k++;
    end
    if (k < n) chk("enable timeout", 8'h00, 8'hff);
  endtask : wait_en

  task automatic per(input logic [7:0] exp);
    logic [7:0] gap = 8'h00;
    wait_en(1);
    do begin
      @(negedge sys_clk);
      gap++;
    end while (sys_clk_en !== 1'b1 && gap < 8'hff);
    chk("enable period", exp, gap);
  endtask : per

  task automatic print_verdict;
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk("core run early", 8'h00, {7'h0, core_run});
    for (int i = 0; i < 200 && core_run !== 1'b1; i++) @(negedge sys_clk);
    chk("core run", 8'h01, {7'h0, core_run});
    rd(4'h0, 8'h5a, "trim reset");
    rd(4'h1, 8'h03, "prescale reset");
    per(8'd8);
    chk("external used", 8'h01, {7'h0, external_clock_used});
    @(posedge sys_clk);
    osc_req <= 1'b1;
    @(negedge sys_clk);
    chk("timer osc ext", 8'h00, {7'h0, timer_osc_enable});
    src_fuse <= 4'h2;
    #1;
    chk("timer osc rc", 8'h01, {7'h0, timer_osc_enable});
    src_fuse <= 4'h0;
    // Wake delay is six cycles; allow eight
    @(posedge sys_clk);
    wake_req <= 1'b1;
    @(posedge sys_clk);
    wake_req <= 1'b0;
    repeat (8) @(negedge sys_clk);
    chk("run after wake", 8'h01, {7'h0, core_run});
    // Clock output fuse off: pin released and held low
    chk("clock out oe on", 8'h01, {7'h0, clock_output_oe});
    @(posedge sys_clk);
    out_fuse <= 1'b0;
    repeat (3) @(negedge sys_clk);
    chk("clock out oe off", 8'h00, {7'h0, clock_output_oe});
    chk("clock out pin off", 8'h00, {7'h0, clock_output_pin});
    out_fuse <= 1'b1;
    // No nonvolatile writes run here, so any trim is allowed
    wr(4'h0, 8'h7f);
    #1;
    chk("trim low range", 8'h7f, {trim_range_bit, trim_fine_value});
    wr(4'h0, 8'h80);
    rd(4'h0, 8'h80, "trim rewrite");
    // Unprotected writes must be refused
    wr(4'h1, 8'h05);
    rd(4'h1, 8'h03, "prescale refused");
    wr(4'h1, 8'h81);
    rd(4'h2, 8'h02, "status no enable");
    wr(4'h1, 8'h80);
    rd(4'h2, 8'h03, "status enable");
    // No interrupt source exists, so the sequence runs unbroken
    wr(4'h1, 8'h80);
    wr(4'h1, 8'h01);
    wait_en(3);
    rd(4'h1, 8'h01, "prescale changed");
    per(8'd2);
    // Window expiry: a late value write is ignored
    wr(4'h1, 8'h80);
    wait_en(5);
    rd(4'h2, 8'h02, "enable expired");
    wr(4'h1, 8'h04);
    rd(4'h1, 8'h01, "late write");
    wr(4'h1, 8'h80);
    wr(4'h1, 8'h04);
    wait_en(3);
    per(8'd16);
    print_verdict();
  end
endmodule : tb_scpt_top
